// [design/lf_receiver_irq_control_regs.vh]
/*
  Register offsets, field positions, reset values and timing counts of the
  low-frequency receiver interrupt and decoder control block.
  Assumes inclusion by bare name from the design files of this block only.
*/
`ifndef LF_RECEIVER_IRQ_CONTROL_REGS_VH
`define LF_RECEIVER_IRQ_CONTROL_REGS_VH

// Byte offsets of the word-aligned registers.
`define LF_CTL_OFS 8'h20
`define LF_STATUS_OFS 8'h24
`define LF_RXDATA_OFS 8'h28
`define LF_IRQ_STATUS_OFS 8'h30
`define LF_IRQ_ENABLE_OFS 8'h34
`define LF_IRQ_CLEAR_OFS 8'h38

// Interrupt enable and control register fields.
`define CTL_DATA_FULL_IE 7
`define CTL_RX_ERROR_IE 6
`define CTL_CARRIER_IE 5
`define CTL_ID_MATCH_IE 4
`define CTL_DECODER_EN 3
`define CTL_VALIDATION_EN 2
`define CTL_TIMEOUT_HI 1
`define CTL_TIMEOUT_LO 0
`define CTL_RESET 8'h0c

// Receive status register fields.
`define ST_DATA_READY 7
`define ST_RX_ERROR 6
`define ST_CARRIER 5
`define ST_ID_MATCH 4
`define ST_OVERFLOW 3
`define ST_END_OF_MSG 2
`define ST_LOW_POWER_SNIFF 1
`define ST_ACKNOWLEDGE 0
`define ST_FLAGS_RESET 6'h00
`define ST_SNIFF_RESET 1'b1

// Event status, enable and clear register fields.
`define IRQ_SYNC_TIMEOUT 0
`define IRQ_OVERFLOW 1
`define IRQ_END_OF_MSG 2
`define IRQ_RAW_DETECTOR 7
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0

// Sync search timeout codes and intervals on the 125 kHz receiver clock.
`define TIMEOUT_OFF 2'b00
`define TIMEOUT_SHORT 2'b01
`define LF_OSC_KHZ 125
`define TIMEOUT_SHORT_MS 8
`define TIMEOUT_LONG_MS 24
`define TIMEOUT_SHORT_TICKS (`TIMEOUT_SHORT_MS * `LF_OSC_KHZ)
`define TIMEOUT_LONG_TICKS (`TIMEOUT_LONG_MS * `LF_OSC_KHZ)

`endif

// [design/sync_level.v]
/*
  Two-stage synchroniser for levels entering the core clock domain.
  Assumes the inputs change slowly compared with the core clock.
*/
`timescale 1ns/100ps
module sync_level #(
  parameter W = 1
) (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Asynchronous level in, synchronised level out.
  input wire [W-1:0] asyncIn,
  output reg [W-1:0] syncOut
);

  reg [W-1:0] stage1Q;

  // The first stage feeds only the second stage.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1Q <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end
    else
    begin
      stage1Q <= asyncIn;
      syncOut <= stage1Q;
    end
  end

endmodule // sync_level

// [design/sync_timeout_timer.v]
/*
  Sync pattern search timer counting ticks of the 125 kHz receiver clock.
  Assumes tickPulse is a one-cycle core clock pulse per receiver clock period
  and that syncSearching and syncFound come from logic on the core clock.
*/
`timescale 1ns/100ps
`include "lf_receiver_irq_control_regs.vh"
module sync_timeout_timer #(
  parameter [11:0] SHORT_TICKS = `TIMEOUT_SHORT_TICKS,
  parameter [11:0] LONG_TICKS = `TIMEOUT_LONG_TICKS
) (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Timing and search status.
  input wire tickPulse,
  input wire syncSearching,
  input wire syncFound,
  input wire [1:0] timeoutSel,
  // One-cycle pulse when the search interval runs out.
  output reg expired
);

  localparam [2:0] IDLE = 3'b001;
  localparam [2:0] COUNT = 3'b010;
  localparam [2:0] DONE = 3'b100;

  reg [2:0] stateQ;
  reg [11:0] countQ;
  wire [11:0] limit;

  // Code 01 picks the short interval; 10 and the reserved 11 the long one.
  assign limit = (timeoutSel == `TIMEOUT_SHORT) ? SHORT_TICKS : LONG_TICKS; // RULE14

  // Counts only while a search runs and a timeout is selected.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateQ <= IDLE;
      countQ <= 12'h000;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      case (stateQ)
        IDLE:
        begin
          countQ <= 12'h000;
          if (syncSearching && !syncFound && timeoutSel != `TIMEOUT_OFF) // RULE10
            stateQ <= COUNT;
        end
        COUNT:
        begin
          if (!syncSearching || syncFound || timeoutSel == `TIMEOUT_OFF)
            stateQ <= IDLE;
          else if (tickPulse)
          begin
            if (countQ + 12'h001 >= limit) // RULE11
            begin
              expired <= 1'b1;
              stateQ <= DONE;
            end
            else
              countQ <= countQ + 12'h001;
          end
        end
        DONE:
        begin
          if (!syncSearching)
            stateQ <= IDLE;
        end
        default:
          stateQ <= IDLE;
      endcase
    end
  end

endmodule // sync_timeout_timer

// [design/lf_receiver_irq_control.v]
/*
  Interrupt enable, decoder control and receive status registers of the
  low-frequency wake-up receiver, reached over an AHB-Lite slave port.
  Assumes the receive event inputs are one-cycle pulses from decoder logic on
  core_clk, and that the receiver clock and raw detector pins are asynchronous.
*/
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "lf_receiver_irq_control_regs.vh"

// Contract
// RULE1: Enabled flags request interrupts, no global mask.
// RULE2: Software clears flags before enabling interrupts.
// RULE3: Bit 7 data-full enable, reset clear.
// RULE4: Bit 6 receive-error enable, reset clear.
// RULE5: Bit 5 carrier enable, data mode needs decoder off.
// RULE6: Bit 4 ID-match enable, reset clear.
// RULE7: Bit 3 decoder enable; off suppresses frame flags.
// RULE8: Software polls raw detector while decoder off.
// RULE9: Bit 2 carrier validation enable, reset set.
// RULE10: Bits 1:0 timeout select; zero never times out.
// RULE11: Missing sync within interval powers receiver off.
// RULE12: Status at 0x24, only with page clear.
// RULE13: Status flags 7:2, sniff bit 1, ack 0.
// RULE14: Code 01 short, 10 and 11 long.
// RULE15: Acknowledge write clears all six flags.
// RULE16: Reading received data clears data ready.
// RULE17: Mode select one is carrier, zero data.
module lf_receiver_irq_control #(
  parameter [11:0] SHORT_TICKS = `TIMEOUT_SHORT_TICKS,
  parameter [11:0] LONG_TICKS = `TIMEOUT_LONG_TICKS
) (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // AHB-Lite slave port.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // Receive events and status from the decoder on core_clk.
  input wire dataReadyEvt,
  input wire rxErrorEvt,
  input wire carrierDetectEvt,
  input wire idMatchEvt,
  input wire rxOverflowEvt,
  input wire endOfMessageEvt,
  input wire syncSearching,
  input wire syncFound,
  input wire carrierModeSel,
  input wire registerPageSel,
  input wire [7:0] rxDataByte,
  // Asynchronous pins.
  input wire receiverOsc125k,
  input wire rawDetectorOut,
  // Control outputs to the receive chain.
  output reg digitalDecoderEn,
  output reg carrierValidationEn,
  output reg lowPowerSniff,
  output reg receiverPowerOff,
  // Interrupt request.
  output reg irqOut
);

  // Bus transfer tracking.
  reg pendingQ;
  reg pendWriteQ;
  reg [5:0] pendAddrQ;
  reg pendPageQ;
  // Register contents.
  reg [7:0] ctlQ;
  reg [5:0] flagsQ;
  reg [`IRQ_WIDTH-1:0] irqStatusQ;
  reg [`IRQ_WIDTH-1:0] irqEnableQ;
  reg oscDlyQ;
  // Derived signals.
  wire [1:0] pinSync;
  wire oscSync;
  wire rawSync;
  wire oscTick;
  wire timeoutPulse;
  wire accept;
  wire doWrite;
  wire doRead;
  wire statusSel;
  wire rxDataSel;
  wire ackWrite;
  wire rxDataRead;
  wire decoderOn;
  wire dataMode;
  wire carrierIrqAllowed;
  wire [5:0] flagSet;
  wire [5:0] flagClr;
  wire [`IRQ_WIDTH-1:0] irqSet;
  wire [`IRQ_WIDTH-1:0] irqClr;
  wire irqD;
  reg [31:0] readMux;

  // Bring both asynchronous pins into the core clock domain.
  sync_level #(
    .W(2)
  ) pinSyncInst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn({rawDetectorOut, receiverOsc125k}),
    .syncOut(pinSync)
  );

  assign oscSync = pinSync[0];
  assign rawSync = pinSync[1];

  // Rising edges of the synchronised receiver clock make one tick each.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      oscDlyQ <= 1'b0;
    else
      oscDlyQ <= oscSync;
  end

  assign oscTick = oscSync & ~oscDlyQ;

  // Sync search timeout on the receiver clock ticks.
  sync_timeout_timer #(
    .SHORT_TICKS(SHORT_TICKS),
    .LONG_TICKS(LONG_TICKS)
  ) timeoutInst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tickPulse(oscTick),
    .syncSearching(syncSearching & ~carrierModeSel),
    .syncFound(syncFound),
    .timeoutSel(ctlQ[`CTL_TIMEOUT_HI:`CTL_TIMEOUT_LO]),
    .expired(timeoutPulse)
  );

  // Address phase is taken when the bus is ready; every data phase has one
  // wait state, so a read always sees the result of the previous write.
  assign accept = hsel & htrans[1] & hready;
  assign doWrite = pendingQ & pendWriteQ;
  assign doRead = accept & ~hwrite;

  // The status and data registers vanish while the page select is set.
  assign statusSel = (haddr[7:2] == `LF_STATUS_OFS >> 2) & ~registerPageSel; // RULE12
  assign rxDataSel = (haddr[7:2] == `LF_RXDATA_OFS >> 2) & ~registerPageSel;
  assign ackWrite = doWrite & ~pendPageQ & (pendAddrQ == `LF_STATUS_OFS >> 2) &
    hwdata[`ST_ACKNOWLEDGE]; // RULE15
  assign rxDataRead = doRead & rxDataSel; // RULE16

  // Track the data phase and drive the bus answer.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pendingQ <= 1'b0;
      pendWriteQ <= 1'b0;
      pendAddrQ <= 6'h00;
      pendPageQ <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      if (accept)
      begin
        pendingQ <= 1'b1;
        pendWriteQ <= hwrite;
        pendAddrQ <= haddr[7:2];
        pendPageQ <= registerPageSel;
        hreadyout <= 1'b0;
        if (!hwrite)
          hrdata <= readMux;
      end
      else
      begin
        pendingQ <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // Read data; unmapped or paged-out addresses read as zero.
  always @*
  begin
    readMux = 32'h00000000;
    case (haddr[7:2])
      `LF_CTL_OFS >> 2:
        readMux[7:0] = ctlQ;
      `LF_STATUS_OFS >> 2:
        if (statusSel)
          readMux[7:0] = {flagsQ, lowPowerSniff, 1'b0}; // RULE13
      `LF_RXDATA_OFS >> 2:
        if (rxDataSel)
          readMux[7:0] = rxDataByte;
      `LF_IRQ_STATUS_OFS >> 2:
      begin
        readMux[`IRQ_WIDTH-1:0] = irqStatusQ;
        readMux[`IRQ_RAW_DETECTOR] = rawSync; // RULE8
      end
      `LF_IRQ_ENABLE_OFS >> 2:
        readMux[`IRQ_WIDTH-1:0] = irqEnableQ;
      default:
        readMux = 32'h00000000;
    endcase
  end

  // Control register and the writable sniff bit of the status register.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctlQ <= `CTL_RESET; // RULE3 RULE4 RULE5 RULE6 RULE7 RULE9 RULE10
      lowPowerSniff <= `ST_SNIFF_RESET; // RULE13
      irqEnableQ <= `IRQ_RESET;
    end
    else if (doWrite)
    begin
      if (pendAddrQ == `LF_CTL_OFS >> 2)
        ctlQ <= hwdata[7:0];
      if (pendAddrQ == `LF_STATUS_OFS >> 2 && !pendPageQ)
        lowPowerSniff <= hwdata[`ST_LOW_POWER_SNIFF];
      if (pendAddrQ == `LF_IRQ_ENABLE_OFS >> 2)
        irqEnableQ <= hwdata[`IRQ_WIDTH-1:0];
    end
  end

  // Control bits driven out to the receive chain.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      digitalDecoderEn <= 1'b1;
      carrierValidationEn <= 1'b1;
      receiverPowerOff <= 1'b0;
    end
    else
    begin
      digitalDecoderEn <= ctlQ[`CTL_DECODER_EN]; // RULE7
      carrierValidationEn <= ctlQ[`CTL_VALIDATION_EN]; // RULE9
      receiverPowerOff <= timeoutPulse; // RULE11
    end
  end

  // Mode qualifiers: frame flags need the decoder and data receive mode.
  assign decoderOn = ctlQ[`CTL_DECODER_EN];
  assign dataMode = ~carrierModeSel; // RULE17
  assign carrierIrqAllowed = carrierModeSel | ~decoderOn; // RULE5

  // Status flag sources, each qualified by mode except the carrier flag, which only needs validation enabled.
  assign flagSet[5] = dataReadyEvt & decoderOn & dataMode; // RULE7
  assign flagSet[4] = rxErrorEvt & decoderOn & dataMode; // RULE7
  assign flagSet[3] = carrierDetectEvt & ctlQ[`CTL_VALIDATION_EN]; // RULE9
  assign flagSet[2] = idMatchEvt & decoderOn & dataMode; // RULE7
  assign flagSet[1] = rxOverflowEvt & decoderOn & dataMode;
  assign flagSet[0] = endOfMessageEvt & decoderOn & dataMode;

  // Acknowledge clears all six flags; reading the data clears data ready.
  assign flagClr = {ackWrite | rxDataRead, {5{ackWrite}}}; // RULE15 RULE16

  // A flag that is set in the same cycle as its clear stays set.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      flagsQ <= `ST_FLAGS_RESET; // RULE13
    else
      flagsQ <= (flagsQ & ~flagClr) | flagSet; // RULE13
  end

  // Event status bits: sync timeout, overflow and end of message.
  assign irqSet[`IRQ_SYNC_TIMEOUT] = timeoutPulse;
  assign irqSet[`IRQ_OVERFLOW] = flagSet[1];
  assign irqSet[`IRQ_END_OF_MSG] = flagSet[0];
  assign irqClr = (doWrite && pendAddrQ == `LF_IRQ_CLEAR_OFS >> 2) ? hwdata[`IRQ_WIDTH-1:0] : `IRQ_RESET;

  // Sticky event bits cleared by writing ones; a new event wins.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      irqStatusQ <= `IRQ_RESET;
    else
      irqStatusQ <= (irqStatusQ & ~irqClr) | irqSet;
  end

  // The request follows any enabled flag, the carrier flag only in carrier mode or with the decoder off, with no global mask in the way.
  assign irqD = (ctlQ[`CTL_DATA_FULL_IE] & flagsQ[5]) | // RULE3
    (ctlQ[`CTL_RX_ERROR_IE] & flagsQ[4]) | // RULE4
    (ctlQ[`CTL_CARRIER_IE] & carrierIrqAllowed & flagsQ[3]) | // RULE5
    (ctlQ[`CTL_ID_MATCH_IE] & flagsQ[2]) | // RULE6
    (|(irqStatusQ & irqEnableQ));

  // Registered interrupt output.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      irqOut <= 1'b0;
    else
      irqOut <= irqD; // RULE1
  end

endmodule // lf_receiver_irq_control

// [test/lf_receiver_irq_control_chk.sv]
/*
  Port checker for lf_receiver_irq_control, bound to every instance.
  Assumes one clock domain, core_clk, with reset_n asynchronous active low.
*/
`timescale 1ns/100ps
module lf_receiver_irq_control_chk (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Bus.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  // Receive side.
  input wire dataReadyEvt,
  input wire rxErrorEvt,
  input wire carrierDetectEvt,
  input wire idMatchEvt,
  input wire rxOverflowEvt,
  input wire endOfMessageEvt,
  input wire syncSearching,
  input wire carrierModeSel,
  input wire registerPageSel,
  // Outputs.
  input wire digitalDecoderEn,
  input wire carrierValidationEn,
  input wire lowPowerSniff,
  input wire receiverPowerOff,
  input wire irqOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Decoded bus transfers and the write data bits that follow them.
  wire taken = hsel && htrans[1] && hready;
  wire wrCtl = taken && hwrite && haddr[7:0] == 8'h20;
  wire wrSt = taken && hwrite && haddr[7:0] == 8'h24;
  wire wDec = hwdata[3];
  wire wVal = hwdata[2];
  wire wSniff = hwdata[1];
  wire act = taken || dataReadyEvt || rxErrorEvt || carrierDetectEvt || idMatchEvt || rxOverflowEvt || endOfMessageEvt;
  reg [2:0] quietCnt_q;
  // Counts cycles since the last bus transfer or receive event; the interrupt may only move soon after one.
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      quietCnt_q <= 3'h0;
    else if (act)
      quietCnt_q <= 3'h0;
    else if (quietCnt_q != 3'h7)
      quietCnt_q <= quietCnt_q + 3'h1;
  reset_vals_a: assert property (
    $rose(reset_n) |-> digitalDecoderEn && carrierValidationEn && lowPowerSniff && !irqOut)
    else $error("wrong output after reset");
  bus_wait_a: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state wrong");
  // The register lands at the data phase edge and the pins follow one edge later.
  ctl_follow_a: assert property (
    wrCtl ##2 1 |=> digitalDecoderEn == $past(wDec) && carrierValidationEn == $past(wVal))
    else $error("control outputs do not follow write");
  sniff_write_a: assert property (wrSt && !registerPageSel ##1 1 |=> lowPowerSniff == $past(wSniff))
    else $error("sniff bit does not follow write");
  page_block_a: assert property (wrSt && registerPageSel ##1 1 |=> $stable(lowPowerSniff))
    else $error("hidden status written");
  power_pulse_a: assert property (receiverPowerOff |=> !receiverPowerOff)
    else $error("power off pulse too long");
  power_cause_a: assert property (receiverPowerOff |-> $past(syncSearching) && !$past(carrierModeSel))
    else $error("power off without data mode search");
  irq_quiet_a: assert property ($changed(irqOut) |-> quietCnt_q < 3'h4)
    else $error("interrupt moved without cause");
  cover property ($rose(irqOut));
  cover property (receiverPowerOff);
  cover property (wrSt && registerPageSel);
endmodule // lf_receiver_irq_control_chk

bind lf_receiver_irq_control lf_receiver_irq_control_chk chk (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .dataReadyEvt, .rxErrorEvt, .carrierDetectEvt, .idMatchEvt, .rxOverflowEvt,
  .endOfMessageEvt, .syncSearching, .carrierModeSel, .registerPageSel, .digitalDecoderEn, .carrierValidationEn,
  .lowPowerSniff, .receiverPowerOff, .irqOut);

// [test/tb_lf_receiver_irq_control.sv]
/*
  Self-checking bench for lf_receiver_irq_control over AHB-Lite.
  Assumes short timeout counts of 4 and 8 receiver clock ticks.
*/
`timescale 1ns/100ps
module tb_lf_receiver_irq_control;
  logic core_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, syncSearching = 1'b0, carrierModeSel = 1'b0;
  logic registerPageSel = 1'b0, receiverOsc125k = 1'b0, rawDetectorOut = 1'b0, syncFound = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] rxDataByte = 8'h0;
  logic [5:0] evt = 6'h0;
  logic [2:0] oscDiv = 3'h0;
  wire hreadyout, hresp, digitalDecoderEn, carrierValidationEn, lowPowerSniff, receiverPowerOff, irqOut;
  wire [31:0] hrdata;
  int n_mismatch = 0;
  int compares = 0;
  // Core clock at 20 MHz.
  always #25 core_clk = ~core_clk;
  // Receiver clock pin, one period every eight core cycles.
  always @(posedge core_clk)
  begin
    oscDiv <= oscDiv + 3'h1;
    receiverOsc125k <= oscDiv[2];
  end
  lf_receiver_irq_control #(.SHORT_TICKS(12'd4), .LONG_TICKS(12'd8)) DUT (.core_clk, .reset_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .dataReadyEvt(evt[5]),
    .rxErrorEvt(evt[4]), .carrierDetectEvt(evt[3]), .idMatchEvt(evt[2]), .rxOverflowEvt(evt[1]),
    .endOfMessageEvt(evt[0]), .syncSearching, .syncFound, .carrierModeSel, .registerPageSel, .rxDataByte,
    .receiverOsc125k, .rawDetectorOut, .digitalDecoderEn, .carrierValidationEn, .lowPowerSniff, .receiverPowerOff,
    .irqOut);
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic waitRdy(inout int k);
    do
    begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
  endtask
  // One single transfer; a hang ends the run.
  task automatic bus(logic [7:0] a, logic w, logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy(k);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy(k);
    r = hrdata;
    if (k >= 40)
    begin
      n_mismatch++;
      report_and_stop;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string msg);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, exp, msg);
  endtask
  // Pulses receive events for one cycle and lets the interrupt settle.
  task automatic ev(logic [5:0] m);
    evt <= m;
    @(posedge core_clk);
    evt <= 6'h0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic t_reset;
    chk({digitalDecoderEn, carrierValidationEn, lowPowerSniff, irqOut, hresp}, 5'h1c, "reset pins");
    rd(8'h20, 32'h0c, "ctl reset");
    rd(8'h24, 32'h02, "status reset");
    rd(8'h34, 32'h0, "enable reset");
    rd(8'h3c, 32'h0, "unmapped");
  endtask
  task automatic t_flags;
    for (int k = 0; k < 6; k++)
    begin
      wr(8'h24, 32'h03);
      ev(6'h1 << k);
      rd(8'h24, {24'h0, 6'h1 << k, 2'h2}, "flag set");
    end
    for (int b = 4; b < 8; b++)
    begin
      wr(8'h24, 32'h03);
      wr(8'h20, 32'h0c | (32'h1 << b));
      ev(6'h1 << (b - 2));
      chk(irqOut, b != 5, "enabled irq");
      wr(8'h24, 32'h03);
      repeat (2) @(posedge core_clk);
      chk(irqOut, 0, "irq after ack");
    end
    rd(8'h24, 32'h02, "ack reads zero");
  endtask
  task automatic t_modes;
    carrierModeSel <= 1'b1;
    wr(8'h20, 32'h2c);
    ev(6'h28);
    rd(8'h24, 32'h22, "carrier mode flags");
    chk(irqOut, 1, "carrier irq");
    wr(8'h24, 32'h03);
    carrierModeSel <= 1'b0;
    wr(8'h20, 32'h24);
    ev(6'h3f);
    rd(8'h24, 32'h22, "decoder off flags");
    chk(irqOut, 1, "carrier irq decoder off");
    wr(8'h24, 32'h03);
    wr(8'h20, 32'h08);
    ev(6'h08);
    rd(8'h24, 32'h02, "validation off");
    chk(carrierValidationEn, 0, "validation pin");
    wr(8'h20, 32'h0c);
  endtask
  task automatic t_rxdata;
    rxDataByte <= 8'h5a;
    ev(6'h20);
    rd(8'h28, 32'h5a, "rx data");
    rd(8'h24, 32'h02, "read clears ready");
    registerPageSel <= 1'b1;
    ev(6'h20);
    rd(8'h24, 32'h0, "status hidden");
    rd(8'h28, 32'h0, "data hidden");
    wr(8'h24, 32'h0);
    chk(lowPowerSniff, 1, "hidden write");
    registerPageSel <= 1'b0;
    wr(8'h24, 32'h0);
    rd(8'h24, 32'h80, "sniff clear, zero ack");
    wr(8'h24, 32'h03);
  endtask
  task automatic t_events;
    // Earlier scenarios left overflow and end-of-message events sticky.
    wr(8'h38, 32'h07);
    rawDetectorOut <= 1'b1;
    wr(8'h34, 32'h02);
    ev(6'h02);
    rd(8'h30, 32'h82, "event status");
    chk(irqOut, 1, "event irq");
    wr(8'h34, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(irqOut, 0, "event masked");
    wr(8'h38, 32'h02);
    rd(8'h30, 32'h80, "event cleared");
    wr(8'h24, 32'h03);
    rawDetectorOut <= 1'b0;
  endtask
  // Searches for sync and counts cycles until the receiver is powered off.
  task automatic tmo(logic [1:0] c, int lo, int hi);
    int k;
    wr(8'h20, {30'h3, c});
    syncSearching <= 1'b1;
    k = 0;
    while (receiverPowerOff !== 1'b1 && k < 120)
    begin
      @(posedge core_clk);
      k++;
    end
    syncSearching <= 1'b0;
    chk(k >= lo && k <= hi, 1, "timeout cycles");
    @(posedge core_clk);
  endtask
  task automatic t_timeout;
    tmo(2'h0, 120, 120);
    tmo(2'h1, 24, 42);
    tmo(2'h2, 56, 74);
    tmo(2'h3, 56, 74);
    rd(8'h30, 32'h1, "timeout event");
    syncFound <= 1'b1;
    tmo(2'h1, 120, 120);
    syncFound <= 1'b0;
    carrierModeSel <= 1'b1;
    tmo(2'h1, 120, 120);
  endtask
  // Reset, then each scenario in turn.
  initial
  begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_flags;
    t_modes;
    t_rxdata;
    t_events;
    t_timeout;
    report_and_stop;
  end
endmodule // tb_lf_receiver_irq_control
